// ==== core/fts_pkg.sv ====
package fts_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned FILT_CLK_HZ = 32_000;
  localparam int unsigned FILT_TICK_CYC = CLK_HZ / FILT_CLK_HZ;
  localparam int unsigned FILT_REJECT_US = 750;
  localparam int unsigned FILT_SAMPLES = (FILT_REJECT_US * FILT_CLK_HZ + 999_999) / 1_000_000;
  localparam logic [11:0] PRE_MAX = 12'(FILT_TICK_CYC - 1);
  localparam logic [4:0] FILT_LAST = 5'(FILT_SAMPLES - 1);

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LIMIT = 8'h04;
  localparam logic [7:0] OFS_READING = 8'h08;
  localparam logic [7:0] OFS_EVT_STAT = 8'h0c;
  localparam logic [7:0] OFS_EVT_MASK = 8'h10;
  localparam logic [7:0] OFS_ENABLE = 8'h14;

  // ---------------------------------------------------------------
  // fan_ctrl_status fields
  // ---------------------------------------------------------------
  localparam int CS_CLK_HI = 6;
  localparam int CS_CLK_LO = 5;
  localparam int CS_FILT_OFF = 4;
  localparam int CS_IE = 3;
  localparam int CS_OVF = 2;
  localparam int CS_OVTH = 1;
  localparam int CS_RDY = 0;

  // event status / mask bits, enable register bit
  localparam int EV_RDY = 0;
  localparam int EV_OVTH = 1;
  localparam int EV_OVF = 2;
  localparam int EN_BIT = 0;

  // ---------------------------------------------------------------
  // reset values and counter maximum
  // ---------------------------------------------------------------
  localparam logic [1:0] CLK_SEL_RST = 2'h1;
  localparam logic [7:0] LIMIT_RST = 8'hff;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  typedef struct packed {
    logic [7:0] addr;
    logic wr_pend;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic tach_s1;
    logic tach_s2;
    logic filt_out;
    logic [4:0] filt_cnt;
    logic [11:0] pre_cnt;
    logic [3:0] rate_cnt;
    logic tach_prev;
    logic seen_edge;
    logic [7:0] count;
    logic [7:0] reading;
    logic [7:0] limit;
    logic [1:0] clk_sel;
    logic filt_off;
    logic ie;
    logic ovf;
    logic ovth;
    logic rdy;
    logic enable;
    logic [2:0] evt_stat;
    logic [2:0] evt_mask;
    logic irq;
  } fts_state_s;

endpackage

// ==== core/fts_monitor.sv ====
// Functional notes
// - rate field picks 16/8/4/2 kHz count clock
// - bit 4 bypasses glitch filter, default filtered
// - interrupt enable raises irq on overflow or over-threshold flags
// - counter passing ffh sets overflow flag
// - overflow clears only by reset or W1C
// - latched count above limit sets over-threshold
// - ready set per edge from second edge while over-threshold is clear
// - ready cleared by reading or by overflow
// - edge latches count unless over-threshold stands, restarts counter
// - overflow clears reading, waits for clear
// - disabled holds counter and reading zero
// - filter samples 32 kHz, rejects under 750us
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module fts_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tach_pulse_in,
  output logic irq
);

  fts_pkg::fts_state_s r;
  fts_pkg::fts_state_s n;

  logic req;
  logic tick32;
  logic rate_tick;
  logic [3:0] rate_mask;
  logic tach_q;
  logic rise;
  logic [7:0] ctrl_val;
  logic [31:0] rd_val;
  logic [2:0] ev_set;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n = r;
    ev_set = 3'h0;
    req = hsel && htrans[1] && hready;
    // reserved bit 7 always reads zero
    ctrl_val = {1'b0, r.clk_sel, r.filt_off, r.ie, r.ovf, r.ovth, r.rdy};

    // -------------------------------------------------------------
    // bus slave: write data phase
    // -------------------------------------------------------------
    if (r.wr_pend)
    begin
      case (r.addr)
        fts_pkg::OFS_CTRL:
        begin
          // bit 7 of the write is dropped
          n.clk_sel = hwdata[fts_pkg::CS_CLK_HI:fts_pkg::CS_CLK_LO];
          n.filt_off = hwdata[fts_pkg::CS_FILT_OFF];
          n.ie = hwdata[fts_pkg::CS_IE];
          if (hwdata[fts_pkg::CS_OVF])
          begin
            n.ovf = 1'b0;
          end
          if (hwdata[fts_pkg::CS_OVTH])
          begin
            n.ovth = 1'b0;
          end
        end
        fts_pkg::OFS_LIMIT: n.limit = hwdata[7:0];
        fts_pkg::OFS_EVT_STAT: n.evt_stat = r.evt_stat & ~hwdata[2:0];
        fts_pkg::OFS_EVT_MASK: n.evt_mask = hwdata[2:0];
        fts_pkg::OFS_ENABLE: n.enable = hwdata[fts_pkg::EN_BIT];
        default: n.enable = n.enable;
      endcase
    end

    // -------------------------------------------------------------
    // bus slave: address phase, read data registered for data phase
    // -------------------------------------------------------------
    case (haddr[7:0])
      fts_pkg::OFS_CTRL: rd_val = {24'h0, ctrl_val};
      fts_pkg::OFS_LIMIT: rd_val = {24'h0, r.limit};
      fts_pkg::OFS_READING: rd_val = {24'h0, r.reading};
      fts_pkg::OFS_EVT_STAT: rd_val = {29'h0, r.evt_stat};
      fts_pkg::OFS_EVT_MASK: rd_val = {29'h0, r.evt_mask};
      fts_pkg::OFS_ENABLE: rd_val = {31'h0, r.enable};
      default: rd_val = 32'h0;
    endcase
    n.wr_pend = req && hwrite;
    if (req)
    begin
      n.addr = haddr[7:0];
    end
    if (req && !hwrite)
    begin
      n.hrdata = rd_val;
      if (haddr[7:0] == fts_pkg::OFS_READING)
      begin
        n.rdy = 1'b0;
      end
    end
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;

    // -------------------------------------------------------------
    // 32 kHz sample tick and counter rate
    // -------------------------------------------------------------
    tick32 = (r.pre_cnt == fts_pkg::PRE_MAX);
    n.pre_cnt = tick32 ? 12'h0 : r.pre_cnt + 12'h1;
    if (tick32)
    begin
      n.rate_cnt = r.rate_cnt + 4'h1;
    end
    // 00 -> every 2nd, 01 -> 4th, 10 -> 8th, 11 -> 16th sample tick
    rate_mask = 4'((5'h2 << r.clk_sel) - 5'h1);
    rate_tick = tick32 && ((r.rate_cnt & rate_mask) == rate_mask);

    // -------------------------------------------------------------
    // tach input: synchroniser, glitch filter, edge detect
    // -------------------------------------------------------------
    n.tach_s1 = tach_pulse_in;
    n.tach_s2 = r.tach_s1;
    if (tick32)
    begin
      // a level must hold for the whole reject window to pass
      if (r.tach_s2 == r.filt_out)
      begin
        n.filt_cnt = 5'h0;
      end
      else if (r.filt_cnt == fts_pkg::FILT_LAST)
      begin
        n.filt_out = r.tach_s2;
        n.filt_cnt = 5'h0;
      end
      else
      begin
        n.filt_cnt = r.filt_cnt + 5'h1;
      end
    end
    // toggling the bypass while running may fake an edge
    tach_q = r.filt_off ? r.tach_s2 : r.filt_out;
    n.tach_prev = tach_q;
    rise = tach_q && !r.tach_prev;

    // -------------------------------------------------------------
    // interval measurement
    // -------------------------------------------------------------
    if (!r.enable)
    begin
      n.count = 8'h0;
      n.reading = 8'h0;
      n.seen_edge = 1'b0;
      n.rdy = 1'b0;
    end
    else if (rise)
    begin
      if (!r.seen_edge)
      begin
        // first edge only starts the interval
        n.seen_edge = 1'b1;
        n.count = 8'h0;
      end
      else if (!r.ovf)
      begin
        n.count = 8'h0;
        if (!r.ovth)
        begin
          n.reading = r.count;
          n.rdy = 1'b1;
          ev_set[fts_pkg::EV_RDY] = 1'b1;
          if (r.count > r.limit)
          begin
            n.ovth = 1'b1;
            ev_set[fts_pkg::EV_OVTH] = 1'b1;
          end
        end
      end
    end
    else if (rate_tick && !r.ovf)
    begin
      // frozen while overflow stands, resumes once it is cleared
      if (r.count == fts_pkg::COUNT_MAX)
      begin
        n.ovf = 1'b1;
        n.reading = 8'h0;
        n.rdy = 1'b0;
        n.count = 8'h0;
        ev_set[fts_pkg::EV_OVF] = 1'b1;
      end
      else
      begin
        n.count = r.count + 8'h1;
      end
    end

    // -------------------------------------------------------------
    // interrupt: set wins over a same-cycle clear
    // -------------------------------------------------------------
    n.evt_stat = n.evt_stat | ev_set;
    n.irq = (n.ie && (n.ovf || n.ovth)) || ((n.evt_stat & n.evt_mask) != 3'h0);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.hreadyout <= 1'b1;
      r.limit <= fts_pkg::LIMIT_RST;
      r.clk_sel <= fts_pkg::CLK_SEL_RST;
    end
    else if (ce)
    begin
      r <= n;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign irq = r.irq;

endmodule

// ==== tb/fts_tach_model.sv ====
`timescale 1ns/1ps
module fts_tach_model (
  input wire logic hclk,
  input wire logic go,
  output logic tach_pulse_in
);
  logic [5:0] cnt_r = 6'h0;
  // one 16-clock high pulse per request, idles low; shorter than the
  // 30-clock gap the bench leaves, so back-to-back requests stay separate edges
  always_ff @(posedge hclk)
  begin
    if (go) cnt_r <= 6'h10;
    else if (cnt_r != 6'h0) cnt_r <= cnt_r - 6'h1;
  end
  assign tach_pulse_in = (cnt_r != 6'h0);
endmodule

// ==== tb/fts_monitor_asserts.sv ====
`timescale 1ns/1ps
module fts_monitor_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq
);
  logic rd_r, wr_r, en_r, en_d, dis_r;
  logic [7:0] ra_r, wa_r;
  wire logic tk = hsel && htrans[1] && hready && ce;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {rd_r, wr_r, en_r, en_d, dis_r, ra_r, wa_r} <= '0;
    end
    else
    begin
      rd_r <= tk && !hwrite;
      wr_r <= tk && hwrite;
      ra_r <= haddr[7:0];
      wa_r <= haddr[7:0];
      if (wr_r && wa_r == fts_pkg::OFS_ENABLE) en_r <= hwdata[0];
      en_d <= en_r;
      dis_r <= tk && !hwrite && haddr[7:0] == fts_pkg::OFS_READING && !en_r && !en_d;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_rdata_hold: assert property (!rd_r |-> $stable(hrdata)) else $error("hrdata moved");
  a_upper_zero: assert property (rd_r |-> hrdata[31:8] == 24'h0) else $error("upper bits set");
  a_unmapped_zero: assert property (rd_r && ra_r >= 8'h18 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rsvd_zero: assert property (rd_r && ra_r == fts_pkg::OFS_CTRL |-> !hrdata[7])
    else $error("reserved bit set");
  a_dis_zero: assert property (dis_r |-> hrdata[7:0] == 8'h0)
    else $error("reading not zero while disabled");
  a_irq_rst: assert property (!$past(hresetn) |-> !irq ##1 !irq)
    else $error("irq high after reset");
endmodule
bind fts_monitor fts_monitor_chk fts_monitor_chk_inst (.hclk(hclk), .hresetn(hresetn),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// ==== tb/fan_tach_speed_monitor_tb_top.sv ====
`timescale 1ns/1ps
module fan_tach_speed_monitor_tb_top;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, hrdata;
  logic hreadyout, hresp, tach, irq;
  int error_cnt = 0, comparisons = 0;
  fts_monitor fts_monitor_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tach_pulse_in(tach), .irq(irq));
  fts_tach_model fts_tach_model_inst (.hclk(hclk), .go(go), .tach_pulse_in(tach));
  initial forever #4 hclk = ~hclk;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task irqis(input logic e);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task pulse(input int gap);
    @(posedge hclk); go <= 1'b1;
    @(posedge hclk); go <= 1'b0;
    repeat (gap) @(posedge hclk);
  endtask
  initial
  begin
    repeat (80000) @(posedge hclk);
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(fts_pkg::OFS_CTRL, 32'h20);
    rd(fts_pkg::OFS_LIMIT, 32'hff);
    rd(fts_pkg::OFS_READING, 32'h0);
    rd(8'h40, 32'h0);
    ahb(1'b1, fts_pkg::OFS_CTRL, 32'hf8);
    rd(fts_pkg::OFS_CTRL, 32'h78);
    ahb(1'b1, fts_pkg::OFS_CTRL, 32'h10);
    $display("test reg_map done");
    ahb(1'b1, fts_pkg::OFS_ENABLE, 32'h1);
    pulse(30);
    rd(fts_pkg::OFS_CTRL, 32'h10);
    pulse(20000);
    pulse(30);
    rd(fts_pkg::OFS_CTRL, 32'h11);
    ahb(1'b0, fts_pkg::OFS_READING, 32'h0);
    chk(32'(q inside {32'h2, 32'h3}), 32'h1);
    rd(fts_pkg::OFS_CTRL, 32'h10);
    irqis(1'b0);
    $display("test speed_read done");
    ahb(1'b1, fts_pkg::OFS_ENABLE, 32'h0);
    rd(fts_pkg::OFS_READING, 32'h0);
    ahb(1'b1, fts_pkg::OFS_LIMIT, 32'h0);
    ahb(1'b1, fts_pkg::OFS_ENABLE, 32'h1);
    pulse(20000);
    pulse(30);
    ahb(1'b0, fts_pkg::OFS_CTRL, 32'h0);
    chk(q & 32'h6, 32'h2);
    irqis(1'b0);
    ahb(1'b1, fts_pkg::OFS_CTRL, 32'h18);
    irqis(1'b1);
    ahb(1'b0, fts_pkg::OFS_CTRL, 32'h0);
    chk(q & 32'h6, 32'h2);
    ahb(1'b1, fts_pkg::OFS_CTRL, 32'h1a);
    irqis(1'b0);
    ahb(1'b0, fts_pkg::OFS_CTRL, 32'h0);
    chk(q & 32'h6, 32'h0);
    $display("test threshold_irq done");
    ahb(1'b0, fts_pkg::OFS_EVT_STAT, 32'h0);
    chk(q & 32'h2, 32'h2);
    ahb(1'b1, fts_pkg::OFS_EVT_MASK, 32'h2);
    irqis(1'b1);
    ahb(1'b1, fts_pkg::OFS_EVT_STAT, 32'h2);
    irqis(1'b0);
    $display("test event_irq done");
    report_and_stop;
  end
endmodule
